//--- core/rsca_alu.v
// rotate and subtract-with-borrow execution slice with its own operand sequencing
`timescale 1ns/1ns
`include "rsca_consts.vh"

// Summary of operation
// - rotate left via flag shifts left, old bit 7 goes to carry and old carry to bit 0.
// - plain rotate right shifts right and copies old bit 0 to bit 7 and to carry.
// - rotate right via flag shifts right, old bit 0 to carry and old carry to bit 7.
// - rotates set zero on a zero result, sign from result bit 7, keep decimal-adjust and half flags.
// - rotates set overflow when the sign bit changed, else clear it.
// - rotate left via flag is opcode 10 direct and 11 pointer, two bytes, 4 cycles.
// - plain rotate right is opcode E0 direct and E1 pointer, two bytes, 4 cycles.
// - rotate right via flag is opcode C0 direct and C1 pointer, two bytes, 4 cycles.
// - subtract with borrow writes dst minus src minus carry and leaves the source alone.
// - subtract with borrow sets carry on a borrow so bytes can chain, else clears it.
// - subtract with borrow sets overflow for opposite signs with result sign equal to source sign.
// - subtract with borrow sets zero and sign from the result and forces decimal-adjust to 1.
// - subtract with borrow clears half on a carry out of bit 3, else sets it.

module rsca_alu #(
  parameter [3:0] WORK_BASE = `RSCA_WORK_BASE  // upper nibble of working register addresses
) (
  input wire core_clk_i,                       // core clock, 20 MHz
  input wire nrst_i,                           // asynchronous reset, active low
  input wire start_i,                          // instruction strobe from sequencer
  input wire [7:0] opcode_i,                   // opcode byte
  input wire [7:0] oper1_i,                    // first operand byte
  input wire [7:0] oper2_i,                    // second operand byte
  input wire [7:0] rf_rdata_i,                 // register file data at rf_addr_o
  input wire flag_wr_i,                        // sequencer flag load strobe
  input wire [`RSCA_FLAG_W-1:0] flag_wdata_i,  // flag load value
  output reg busy_o,                           // instruction in progress
  output reg done_o,                           // one-cycle end of instruction
  output reg bad_op_o,                         // one-cycle pulse, opcode not handled
  output reg [7:0] rf_addr_o,                  // register file address
  output reg rf_we_o,                          // register file write enable
  output reg [7:0] rf_wdata_o,                 // register file write data
  output reg [`RSCA_FLAG_W-1:0] flags_o,       // flags C Z S V D H
  output reg [1:0] ilen_o                      // byte length of the instruction taken
);

  // ************************************************
  // states and decode helpers
  // ************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PTR = 3'h1;
  localparam [2:0] ST_SRC = 3'h2;
  localparam [2:0] ST_DST = 3'h3;
  localparam [2:0] ST_WB = 3'h4;
  localparam [2:0] ST_WAIT = 3'h5;

  // working register address from a 4-bit field
  function [7:0] work_addr;
    input [3:0] nib;
    begin
      work_addr = {WORK_BASE, nib};
    end
  endfunction

  // opcode membership and operation kind
  function [2:0] op_kind;
    input [7:0] op;
    begin
      case (op)
        `RSCA_OP_RLC_R, `RSCA_OP_RLC_IR: op_kind = {1'b1, `RSCA_K_RLC};
        `RSCA_OP_RR_R, `RSCA_OP_RR_IR: op_kind = {1'b1, `RSCA_K_RR};
        `RSCA_OP_RRC_R, `RSCA_OP_RRC_IR: op_kind = {1'b1, `RSCA_K_RRC};
        `RSCA_OP_SBC_RR, `RSCA_OP_SBC_RIR, `RSCA_OP_SBC_MM,
        `RSCA_OP_SBC_MIM, `RSCA_OP_SBC_IMM: op_kind = {1'b1, `RSCA_K_SBC};
        default: op_kind = 3'h0;
      endcase
    end
  endfunction

  // cycle count of each encoding
  function [2:0] op_cycles;
    input [7:0] op;
    begin
      case (op)
        `RSCA_OP_SBC_RIR, `RSCA_OP_SBC_MM, `RSCA_OP_SBC_MIM,
        `RSCA_OP_SBC_IMM: op_cycles = `RSCA_CYC_LONG;
        default: op_cycles = `RSCA_CYC_SHORT;
      endcase
    end
  endfunction

  // ************************************************
  // registers
  // ************************************************
  reg [2:0] state_q;
  reg [2:0] cnt_q;
  reg [2:0] ncyc_q;
  reg [1:0] kind_q;
  reg sbc_q;
  reg imm_q;
  reg [7:0] dst_addr_q;
  reg [7:0] src_q;

  wire [7:0] calc_res;
  wire [`RSCA_FLAG_W-1:0] calc_flags;
  wire [2:0] start_kind;
  wire start_ok;
  wire last_cyc;

  assign start_kind = op_kind(opcode_i);
  assign start_ok = start_kind[2];
  // last cycle of the instruction: one less than its count after the start edge
  assign last_cyc = busy_o && (cnt_q == ncyc_q - 3'h1);

  // ************************************************
  // result and flag calculator
  // ************************************************
  rsca_flagcalc u_calc (
    .kind_i(kind_q),
    .dst_i(rf_rdata_i),
    .src_i(src_q),
    .flags_i(flags_o),
    .res_o(calc_res),
    .flags_o(calc_flags)
  );

  // ************************************************
  // operand sequencing
  // ************************************************
  // every read is combinational on rf_addr_o, so each operand costs one cycle
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      ncyc_q <= `RSCA_CYC_SHORT;
      kind_q <= `RSCA_K_RLC;
      sbc_q <= 1'b0;
      imm_q <= 1'b0;
      dst_addr_q <= 8'h00;
      src_q <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      bad_op_o <= 1'b0;
      rf_addr_o <= 8'h00;
      rf_we_o <= 1'b0;
      rf_wdata_o <= 8'h00;
      ilen_o <= `RSCA_LEN_TWO;
    end else begin
      done_o <= 1'b0;
      bad_op_o <= 1'b0;
      cnt_q <= cnt_q + 3'h1;
      case (state_q)
        ST_IDLE: begin
          rf_we_o <= 1'b0;
          if (start_i && !start_ok) begin
            // unknown opcodes are refused with no side effect
            bad_op_o <= 1'b1;
          end else if (start_i) begin
            busy_o <= 1'b1;
            cnt_q <= 3'h1;
            kind_q <= start_kind[1:0];
            sbc_q <= (start_kind[1:0] == `RSCA_K_SBC);
            imm_q <= 1'b0;
            // subtract encodings take 4 or 6 cycles
            ncyc_q <= op_cycles(opcode_i);
            ilen_o <= `RSCA_LEN_TWO;
            case (opcode_i)
              `RSCA_OP_RLC_R, `RSCA_OP_RR_R, `RSCA_OP_RRC_R: begin
                dst_addr_q <= oper1_i;
                rf_addr_o <= oper1_i;
                state_q <= ST_DST;
              end
              `RSCA_OP_RLC_IR, `RSCA_OP_RR_IR, `RSCA_OP_RRC_IR: begin
                rf_addr_o <= oper1_i;
                state_q <= ST_PTR;
              end
              // two working registers, dst in high nibble
              `RSCA_OP_SBC_RR: begin
                dst_addr_q <= work_addr(oper1_i[7:4]);
                rf_addr_o <= work_addr(oper1_i[3:0]);
                state_q <= ST_SRC;
              end
              // working dst, pointer in a working register
              `RSCA_OP_SBC_RIR: begin
                dst_addr_q <= work_addr(oper1_i[7:4]);
                rf_addr_o <= work_addr(oper1_i[3:0]);
                state_q <= ST_PTR;
              end
              // three-byte MM and MIM forms put src before dst
              `RSCA_OP_SBC_MM: begin
                ilen_o <= `RSCA_LEN_THREE;
                dst_addr_q <= oper2_i;
                rf_addr_o <= oper1_i;
                state_q <= ST_SRC;
              end
              `RSCA_OP_SBC_MIM: begin
                ilen_o <= `RSCA_LEN_THREE;
                dst_addr_q <= oper2_i;
                rf_addr_o <= oper1_i;
                state_q <= ST_PTR;
              end
              default: begin
                // immediate form: dst then literal
                ilen_o <= `RSCA_LEN_THREE;
                imm_q <= 1'b1;
                src_q <= oper2_i;
                dst_addr_q <= oper1_i;
                rf_addr_o <= oper1_i;
                state_q <= ST_DST;
              end
            endcase
          end
        end
        ST_PTR: begin
          // pointer value becomes an address, pointer itself untouched
          rf_addr_o <= rf_rdata_i;
          if (sbc_q) begin
            state_q <= ST_SRC;
          end else begin
            dst_addr_q <= rf_rdata_i;
            state_q <= ST_DST;
          end
        end
        ST_SRC: begin
          // source is only read, never written
          src_q <= rf_rdata_i;
          rf_addr_o <= dst_addr_q;
          state_q <= ST_DST;
        end
        ST_DST: begin
          // write-back issued; commits at the end of the next cycle
          rf_addr_o <= dst_addr_q;
          rf_wdata_o <= calc_res;
          rf_we_o <= 1'b1;
          state_q <= ST_WB;
        end
        ST_WB: begin
          rf_we_o <= 1'b0;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          rf_we_o <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          rf_we_o <= 1'b0;
        end
      endcase
      // end of instruction at the documented cycle count
      if (last_cyc) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
        rf_we_o <= 1'b0;
        state_q <= ST_IDLE;
      end
    end
  end

  // ************************************************
  // flag register
  // ************************************************
  // the block's own update wins; sequencer loads are ignored while busy
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_o <= `RSCA_FLAG_RST;
    end else if (state_q == ST_DST && busy_o) begin
      // rotate and subtract flags taken with the result
      flags_o <= calc_flags;
    end else if (flag_wr_i && !busy_o) begin
      flags_o <= flag_wdata_i;
    end
  end

endmodule

//--- core/rsca_flagcalc.v
// combinational result and flag calculator for rotates and subtract with borrow
`timescale 1ns/1ns
`include "rsca_consts.vh"

module rsca_flagcalc (
  input wire [1:0] kind_i,                     // operation kind
  input wire [7:0] dst_i,                      // destination operand value
  input wire [7:0] src_i,                      // source operand value
  input wire [`RSCA_FLAG_W-1:0] flags_i,       // flags before the operation
  output reg [7:0] res_o,                      // result byte
  output reg [`RSCA_FLAG_W-1:0] flags_o        // flags after the operation
);

  wire cin;
  wire [8:0] diff;
  wire [4:0] low_sum;

  assign cin = flags_i[`RSCA_F_C];
  // dst - src - c, the ninth bit is the borrow
  assign diff = {1'b0, dst_i} - {1'b0, src_i} - {8'h00, cin};
  // low nibble of dst + ~src + (1 - c); its carry out means no nibble borrow
  assign low_sum = {1'b0, dst_i[3:0]} + {1'b0, ~src_i[3:0]} + {4'h0, ~cin};

  // ************************************************
  // result and flag selection
  // ************************************************
  always @* begin
    flags_o = flags_i;
    res_o = dst_i;
    case (kind_i)
      `RSCA_K_RLC: begin
        res_o = {dst_i[6:0], cin};
        flags_o[`RSCA_F_C] = dst_i[7];
      end
      `RSCA_K_RR: begin
        res_o = {dst_i[0], dst_i[7:1]};
        flags_o[`RSCA_F_C] = dst_i[0];
      end
      `RSCA_K_RRC: begin
        res_o = {cin, dst_i[7:1]};
        flags_o[`RSCA_F_C] = dst_i[0];
      end
      default: begin
        res_o = diff[7:0];
        flags_o[`RSCA_F_C] = diff[8];
        // opposite signs, result sign as source
        flags_o[`RSCA_F_V] = (dst_i[7] ^ src_i[7]) & ~(diff[7] ^ src_i[7]);
        flags_o[`RSCA_F_D] = 1'b1;
        // half flag marks a nibble borrow
        flags_o[`RSCA_F_H] = ~low_sum[4];
      end
    endcase
    // zero and sign from the result, D and H kept on rotates
    flags_o[`RSCA_F_Z] = (res_o == 8'h00);
    flags_o[`RSCA_F_S] = res_o[7];
    // overflow when the sign bit changed
    if (kind_i != `RSCA_K_SBC) begin
      flags_o[`RSCA_F_V] = res_o[7] ^ dst_i[7];
    end
  end

endmodule

//--- include/rsca_consts.vh
// constants for the rotate/subtract-with-borrow datapath slice
`ifndef RSCA_CONSTS_VH
`define RSCA_CONSTS_VH

// opcodes, direct, pointer and immediate forms
`define RSCA_OP_RLC_R    8'h10
`define RSCA_OP_RLC_IR   8'h11
`define RSCA_OP_RR_R     8'hE0
`define RSCA_OP_RR_IR    8'hE1
`define RSCA_OP_RRC_R    8'hC0
`define RSCA_OP_RRC_IR   8'hC1
`define RSCA_OP_SBC_RR   8'h32
`define RSCA_OP_SBC_RIR  8'h33
`define RSCA_OP_SBC_MM   8'h34
`define RSCA_OP_SBC_MIM  8'h35
`define RSCA_OP_SBC_IMM  8'h36

// operation kinds handed to the flag calculator
`define RSCA_K_RLC 2'h0
`define RSCA_K_RR  2'h1
`define RSCA_K_RRC 2'h2
`define RSCA_K_SBC 2'h3

// flag vector bit positions
`define RSCA_F_C 0
`define RSCA_F_Z 1
`define RSCA_F_S 2
`define RSCA_F_V 3
`define RSCA_F_D 4
`define RSCA_F_H 5
`define RSCA_FLAG_W 6
`define RSCA_FLAG_RST 6'h00

// instruction lengths in core cycles and bytes
`define RSCA_CYC_SHORT 3'h4
`define RSCA_CYC_LONG  3'h6
`define RSCA_LEN_TWO   2'h2
`define RSCA_LEN_THREE 2'h3

// working register bank base (upper address nibble)
`define RSCA_WORK_BASE 4'hC

`endif

//--- verification/rsca_alu_assertions.sv
// checker for the rotate and subtract-with-borrow slice
`timescale 1ns/1ns
`include "rsca_consts.vh"
module rsca_alu_checker (
  input wire core_clk_i,                       // clock
  input wire nrst_i,                           // reset, active low
  input wire start_i,                          // strobe
  input wire [7:0] opcode_i,                   // opcode
  input wire [7:0] oper1_i,                    // operand 1
  input wire [7:0] oper2_i,                    // operand 2
  input wire [7:0] rf_rdata_i,                 // read data
  input wire flag_wr_i,                        // flag load
  input wire [`RSCA_FLAG_W-1:0] flag_wdata_i,  // flag value
  input wire busy_o,                           // busy
  input wire done_o,                           // done
  input wire bad_op_o,                         // refused opcode
  input wire [7:0] rf_addr_o,                  // address
  input wire rf_we_o,                          // write enable
  input wire [7:0] rf_wdata_o,                 // write data
  input wire [`RSCA_FLAG_W-1:0] flags_o,       // flags
  input wire [1:0] ilen_o                      // length
);
  reg [7:0] op_q;
  wire take = start_i && !busy_o;
  wire shrt = take && (opcode_i == 8'h10 || opcode_i == 8'h11 || opcode_i == 8'hE0 || opcode_i == 8'hE1 ||
              opcode_i == 8'hC0 || opcode_i == 8'hC1 || opcode_i == 8'h32);
  wire lng = take && opcode_i >= 8'h33 && opcode_i <= 8'h36;
  wire bad = take && !shrt && !lng;
  wire rot = op_q[7:4] == 4'h1 || op_q[7:4] == 4'hE || op_q[7:4] == 4'hC;
  wire subtract_with_borrow = op_q[7:4] == 4'h3;
  // opcode of the running instruction, so write-time checks know its kind
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      op_q <= 8'h00;
    else if (take)
      op_q <= opcode_i;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_short_done: assert property (shrt |-> ##4 done_o)
    else $error("short instruction did not end after 4 cycles");
  a_short_busy: assert property (shrt |=> busy_o [*3] ##1 !busy_o)
    else $error("busy span wrong for short instruction");
  a_long_done: assert property (lng |-> ##6 done_o)
    else $error("long instruction did not end after 6 cycles");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_bad_refused: assert property (bad |=> bad_op_o && !busy_o && !rf_we_o)
    else $error("unsupported opcode not refused");
  a_rot_flags: assert property (rf_we_o && rot |-> flags_o[1] == (rf_wdata_o == 8'h00) && flags_o[2] == rf_wdata_o[7])
    else $error("rotate zero or sign flag wrong");
  a_rot_keep: assert property (rf_we_o && rot |-> flags_o[5:4] == $past(flags_o[5:4]))
    else $error("rotate changed decimal-adjust or half flag");
  a_sbc_dflag: assert property (rf_we_o && subtract_with_borrow |-> flags_o[4] && flags_o[1] == (rf_wdata_o == 8'h00))
    else $error("subtract flags wrong");
  a_one_write: assert property (rf_we_o |=> !rf_we_o)
    else $error("more than one write cycle");
  a_len_code: assert property (done_o |-> ilen_o == ((op_q >= 8'h34 && op_q <= 8'h36) ? 2'h3 : 2'h2))
    else $error("instruction length wrong");
  a_flag_load: assert property (flag_wr_i && !busy_o && !start_i |=> flags_o == $past(flag_wdata_i))
    else $error("flag load not taken");
  cover property (shrt);
  cover property (lng);
  cover property (bad);
  cover property (rf_we_o && subtract_with_borrow && flags_o[0]);
endmodule
bind rsca_alu rsca_alu_checker u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(start_i),
  .opcode_i(opcode_i), .oper1_i(oper1_i), .oper2_i(oper2_i), .rf_rdata_i(rf_rdata_i), .flag_wr_i(flag_wr_i),
  .flag_wdata_i(flag_wdata_i), .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o), .rf_addr_o(rf_addr_o),
  .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o), .flags_o(flags_o), .ilen_o(ilen_o));

//--- verification/rsca_alu_tb.sv
// self-checking bench for the rotate and subtract-with-borrow slice
`timescale 1ns/1ns
`include "rsca_consts.vh"
module testbench;
  reg core_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg start_i = 1'b0;
  reg [7:0] opcode_i = 8'h00;
  reg [7:0] oper1_i = 8'h00;
  reg [7:0] oper2_i = 8'h00;
  reg flag_wr_i = 1'b0;
  reg [5:0] flag_wdata_i = 6'h00;
  wire [7:0] rf_rdata_i;
  wire [7:0] rf_addr_o;
  wire [7:0] rf_wdata_o;
  wire busy_o, done_o, bad_op_o, rf_we_o;
  wire [5:0] flags_o;
  wire [1:0] ilen_o;
  reg [7:0] mem [0:255];
  integer fails = 0;
  integer n_tests = 0;
  integer i;
  always #25 core_clk_i = ~core_clk_i;
  // register file: read is combinational, a write lands at the edge ending the strobe
  assign rf_rdata_i = mem[rf_addr_o];
  always @(posedge core_clk_i) if (rf_we_o) mem[rf_addr_o] <= rf_wdata_o;
  rsca_alu uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .start_i(start_i), .opcode_i(opcode_i),
    .oper1_i(oper1_i), .oper2_i(oper2_i), .rf_rdata_i(rf_rdata_i), .flag_wr_i(flag_wr_i),
    .flag_wdata_i(flag_wdata_i), .busy_o(busy_o), .done_o(done_o), .bad_op_o(bad_op_o), .rf_addr_o(rf_addr_o),
    .rf_we_o(rf_we_o), .rf_wdata_o(rf_wdata_o), .flags_o(flags_o), .ilen_o(ilen_o));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // flags are loaded only while idle, so callers enter just after an edge
  task load_flags(input [5:0] f);
    begin
      flag_wr_i = 1'b1;
      flag_wdata_i = f;
      @(posedge core_clk_i);
      #1 flag_wr_i = 1'b0;
    end
  endtask
  task run(input [7:0] op, o1, o2, da, sa, er, input [5:0] ef, input integer en, input [1:0] el);
    reg [7:0] sv;
    integer n;
    begin
      sv = mem[sa];
      start_i = 1'b1;
      opcode_i = op;
      oper1_i = o1;
      oper2_i = o2;
      @(posedge core_clk_i);
      #1 start_i = 1'b0;
      n = 1;
      while (done_o !== 1'b1 && n < 12) begin
        @(posedge core_clk_i);
        #1 n = n + 1;
      end
      chk("result", er, mem[da]);
      chk("source", sv, mem[sa]);
      chk("flags", {2'b00, ef}, {2'b00, flags_o});
      chk("cycles", en[7:0], n[7:0]);
      chk("length", {6'h00, el}, {6'h00, ilen_o});
    end
  endtask
  task rot_test(input [7:0] op, input [7:0] v, input c);
    reg [7:0] r;
    reg co;
    begin
      mem[8'h40] = v;
      mem[8'h41] = 8'h40;
      load_flags({2'b11, 3'b000, c});
      case (op[7:4])
        4'h1: r = {v[6:0], c};
        4'hE: r = {v[0], v[7:1]};
        default: r = {c, v[7:1]};
      endcase
      co = (op[7:4] == 4'h1) ? v[7] : v[0];
      // a pointer form names 41, which holds the target address 40
      run(op, op[0] ? 8'h41 : 8'h40, 8'h00, 8'h40, 8'h41, r, {2'b11, r[7] ^ v[7], r[7], r == 8'h00, co}, 4, 2'h2);
      $display("rotate %h finished", op);
    end
  endtask
  task sbc_test(input [7:0] op, input [7:0] d, s, input c, input ld);
    reg [8:0] full;
    reg [4:0] lo;
    reg [7:0] da, sa, o1;
    begin
      full = {1'b0, d} - {1'b0, s} - {8'h00, c};
      lo = {1'b0, d[3:0]} + {1'b0, ~s[3:0]} + {4'h0, ~c};
      da = (op < 8'h34) ? 8'hC1 : 8'h51;
      sa = (op == 8'h32) ? 8'hC2 : (op == 8'h33) ? 8'h30 : 8'h50;
      o1 = (op < 8'h34) ? 8'h12 : (op == 8'h35) ? 8'h52 : (op == 8'h36) ? 8'h51 : 8'h50;
      mem[8'hC2] = 8'h30;
      mem[8'h52] = 8'h50;
      mem[da] = d;
      mem[sa] = s;
      if (ld)
        load_flags({5'h00, c});
      run(op, o1, (op == 8'h36) ? s : 8'h51, da, sa, full[7:0],
        {~lo[4], 1'b1, (d[7] ^ s[7]) & (full[7] == s[7]), full[7], full[7:0] == 8'h00, full[8]},
        (op == 8'h32) ? 4 : 6, (op > 8'h33) ? 2'h3 : 2'h2);
      $display("subtract %h finished", op);
    end
  endtask
  task bad_test;
    reg [5:0] fs;
    begin
      fs = flags_o;
      start_i = 1'b1;
      opcode_i = 8'h22;
      @(posedge core_clk_i);
      #1 start_i = 1'b0;
      chk("bad_op", 8'h01, {7'h00, bad_op_o});
      chk("busy", 8'h00, {7'h00, busy_o});
      chk("flags", {2'b00, fs}, {2'b00, flags_o});
      $display("refused opcode finished");
    end
  endtask
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = i[7:0] ^ 8'h5A;
    repeat (5) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    chk("reset flags", 8'h00, {2'b00, flags_o});
    rot_test(8'h10, 8'hAA, 1'b0);
    rot_test(8'h11, 8'h80, 1'b0);
    rot_test(8'hE0, 8'h31, 1'b0);
    rot_test(8'hE1, 8'h02, 1'b1);
    rot_test(8'hC0, 8'h55, 1'b1);
    rot_test(8'hC1, 8'h01, 1'b0);
    sbc_test(8'h32, 8'h10, 8'h03, 1'b1, 1'b1);
    sbc_test(8'h32, 8'h80, 8'h01, 1'b0, 1'b1);
    sbc_test(8'h33, 8'h20, 8'h0A, 1'b1, 1'b1);
    sbc_test(8'h34, 8'h20, 8'h03, 1'b1, 1'b1);
    sbc_test(8'h35, 8'h20, 8'h0A, 1'b0, 1'b1);
    sbc_test(8'h36, 8'h01, 8'h8A, 1'b1, 1'b1);
    sbc_test(8'h34, 8'h00, 8'h01, 1'b0, 1'b1);
    sbc_test(8'h34, 8'h05, 8'h00, 1'b1, 1'b0);
    bad_test;
    report_and_stop;
  end
  // watchdog: the sequence needs under 100 cycles, the limit is 2000
  initial begin
    #(50 * 2000);
    fails = fails + 1;
    report_and_stop;
  end
endmodule
